// ---- verilog/dcp_pkg.sv ----
package dcp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned DCP_CLK_MHZ     = 200;
  localparam int unsigned DCP_REF_MIN_MHZ = 4;
  localparam int unsigned DCP_REF_MAX_MHZ = 16;
  // Longest reference period rounds down, shortest rounds up
  localparam int unsigned DCP_REF_MAX_CYC = DCP_CLK_MHZ / DCP_REF_MIN_MHZ;
  localparam int unsigned DCP_REF_MIN_CYC = (DCP_CLK_MHZ + DCP_REF_MAX_MHZ - 1) / DCP_REF_MAX_MHZ;

  // ****************************************
  // Loop settings
  // ****************************************
  localparam int unsigned DCP_PLL_MULT   = 4;
  localparam int unsigned DCP_LOCK_EDGES = 8;
  localparam int unsigned DCP_CNT_W      = 8;
  localparam int unsigned DCP_LOCK_W     = 4;
  localparam int unsigned DCP_ACC_W      = DCP_CNT_W + 1;

  // ****************************************
  // Power modes and carriers
  // ****************************************
  typedef enum logic [1:0] {
    DCP_NORMAL,
    DCP_IDLE,
    DCP_SLEEP,
    DCP_HALT
  } dcp_mode_t;

  typedef struct packed {
    logic      valid;
    dcp_mode_t mode;
  } dcp_mode_req_t;

  typedef struct packed {
    logic irq_int;
    logic irq_ext;
    logic nmi;
  } dcp_wake_t;

  typedef struct packed {
    logic                 ref_prev;
    logic [DCP_CNT_W-1:0] cnt;
    logic [DCP_CNT_W-1:0] period;
    logic [DCP_ACC_W-1:0] acc;
    logic [DCP_LOCK_W-1:0] lock_cnt;
    logic                 locked;
    logic                 tick;
  } dcp_pll_state_t;

  typedef struct packed {
    dcp_mode_t mode;
    logic      ref_last;
    logic      proc_clk;
    logic      core_en;
    logic      periph_en;
    logic      wake;
  } dcp_top_state_t;

endpackage

// ---- verilog/dcp_pll.sv ----
module dcp_pll import dcp_pkg::*; #(
  parameter int unsigned MULT       = DCP_PLL_MULT,
  parameter int unsigned LOCK_EDGES = DCP_LOCK_EDGES
) (
  // Clock, reset, enable
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  // Reference
  input  wire logic ref_clock_in,
  // Loop outputs
  output logic      tick_out,
  output logic      locked_out
);

  // ****************************************
  // State
  // ****************************************
  localparam logic [DCP_CNT_W-1:0]  MAX_CYC = DCP_CNT_W'(DCP_REF_MAX_CYC);
  localparam logic [DCP_CNT_W-1:0]  MIN_CYC = DCP_CNT_W'(DCP_REF_MIN_CYC);
  localparam logic [DCP_ACC_W-1:0]  STEP    = DCP_ACC_W'(2 * MULT);
  localparam logic [DCP_LOCK_W-1:0] LOCK_LAST = DCP_LOCK_W'(LOCK_EDGES - 1);

  dcp_pll_state_t s;
  dcp_pll_state_t next_s;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [DCP_CNT_W-1:0] diff;
    logic [DCP_ACC_W-1:0] sum;
    diff = '0;
    sum = '0;
    next_s = s;
    next_s.tick = 1'b0;
    if (ce_in) begin
      next_s.ref_prev = ref_clock_in;
      // Period measured on reference rising edges
      if (ref_clock_in && !s.ref_prev) begin
        next_s.period = s.cnt;
        next_s.cnt = DCP_CNT_W'(1);
        diff = (s.cnt >= s.period) ? s.cnt - s.period : s.period - s.cnt;
        if (s.cnt >= MIN_CYC && s.cnt <= MAX_CYC && diff <= DCP_CNT_W'(1)) begin
          if (s.lock_cnt == LOCK_LAST) begin
            next_s.locked = 1'b1;
          end else begin
            next_s.lock_cnt = s.lock_cnt + DCP_LOCK_W'(1);
          end
        end else begin
          next_s.lock_cnt = '0;
          next_s.locked = 1'b0;
        end
      end else if (s.cnt > MAX_CYC) begin
        // Stopped reference drops lock
        next_s.lock_cnt = '0;
        next_s.locked = 1'b0;
      end else begin
        next_s.cnt = s.cnt + DCP_CNT_W'(1);
      end
      // Phase accumulator: 2*MULT half periods per reference period
      if (s.locked) begin
        sum = s.acc + STEP;
        if (sum >= {1'b0, s.period}) begin
          next_s.acc = sum - {1'b0, s.period};
          next_s.tick = 1'b1;
        end else begin
          next_s.acc = sum;
        end
      end else begin
        next_s.acc = '0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.tick;
  assign locked_out = s.locked;

  // ****************************************
  // Checks
  // ****************************************
  no_tick_unlocked_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !s.locked |=> !tick_out) else $error("loop tick without lock");

  // Short reference periods need two ticks in a row, never three
  tick_spacing_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick_out ##1 tick_out) |=> !tick_out) else $error("loop ticks three in a row");

  lock_window_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(locked_out) |-> (s.period >= MIN_CYC && s.period <= MAX_CYC))
    else $error("lock outside reference window");

endmodule

// ---- verilog/dcp_clock_power.sv ----
module dcp_clock_power import dcp_pkg::*; (
  // Clock, reset, enable
  input  wire logic    clk_in,
  input  wire logic    resetn_in,
  input  wire logic    ce_in,
  // Reference and clock selection
  input  wire logic    ref_clock_in,
  input  wire logic    pll_bypass_in,
  // Mode command and wake sources
  input  dcp_mode_req_t mode_req_in,
  input  dcp_wake_t    wake_in,
  // Clock outputs
  output logic         proc_clock_out,
  output logic         core_clk_en_out,
  output logic         periph_clk_en_out,
  // Status
  output dcp_mode_t    mode_out,
  output logic         pll_locked_out,
  output logic         wake_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Loop
  // ****************************************
  logic pll_tick;
  logic pll_locked;

  // Loop has no mode input, so it never stops in low-power modes
  dcp_pll #(
    .MULT       (DCP_PLL_MULT),
    .LOCK_EDGES (DCP_LOCK_EDGES)
  ) u_pll (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n),
    .ce_in        (ce_in),
    .ref_clock_in (ref_clock_in),
    .tick_out     (pll_tick),
    .locked_out   (pll_locked)
  );

  // ****************************************
  // State
  // ****************************************
  dcp_top_state_t s;
  dcp_top_state_t next_s;
  logic           bypass_tick;
  logic           proc_tick;
  logic           proc_rise;
  logic           any_wake;

  // Bypass edges need no counter, so a stopped reference just holds the clock
  assign bypass_tick = ref_clock_in != s.ref_last;
  assign proc_tick = pll_bypass_in ? bypass_tick : pll_tick;
  assign proc_rise = proc_tick && !s.proc_clk;
  assign any_wake = wake_in.irq_int || wake_in.irq_ext || wake_in.nmi;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.core_en = 1'b0;
    next_s.periph_en = 1'b0;
    next_s.wake = 1'b0;
    if (ce_in) begin
      next_s.ref_last = ref_clock_in;
      if (proc_tick) begin
        next_s.proc_clk = !s.proc_clk;
      end
      next_s.core_en = proc_rise && (s.mode == DCP_NORMAL);
      next_s.periph_en = proc_rise && (s.mode == DCP_NORMAL || s.mode == DCP_IDLE);
      case (s.mode)
        DCP_NORMAL: begin
          if (mode_req_in.valid) begin
            next_s.mode = mode_req_in.mode;
          end
        end
        DCP_IDLE: begin
          if (any_wake) begin
            next_s.mode = DCP_NORMAL;
            next_s.wake = 1'b1;
          end
        end
        DCP_SLEEP: begin
          // NMI arrives on a pin, so it counts as external
          if (wake_in.irq_ext || wake_in.nmi) begin
            next_s.mode = DCP_NORMAL;
            next_s.wake = 1'b1;
          end
        end
        DCP_HALT: begin
          if (wake_in.nmi) begin
            next_s.mode = DCP_NORMAL;
            next_s.wake = 1'b1;
          end
        end
        default: begin
          next_s.mode = DCP_NORMAL;
        end
      endcase
    end
  end

  // Reset itself is the last wake source: it always lands in normal mode
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign proc_clock_out = s.proc_clk;
  assign core_clk_en_out = s.core_en;
  assign periph_clk_en_out = s.periph_en;
  assign mode_out = s.mode;
  assign pll_locked_out = pll_locked;
  assign wake_out = s.wake;

  // ****************************************
  // Checks
  // ****************************************
  normal_run_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_NORMAL && proc_rise) |=> (core_clk_en_out && periph_clk_en_out))
    else $error("normal mode did not clock core and peripherals");

  idle_core_off_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_IDLE && proc_rise) |=> (!core_clk_en_out && periph_clk_en_out))
    else $error("idle mode clock gating wrong");

  idle_wake_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_IDLE && any_wake) |=> (mode_out == DCP_NORMAL && wake_out))
    else $error("idle mode missed a wake");

  sleep_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_SLEEP && !wake_in.irq_ext && !wake_in.nmi)
      |=> (mode_out == DCP_SLEEP && !core_clk_en_out && !periph_clk_en_out))
    else $error("sleep mode left or clocked without external wake");

  halt_nmi_only_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_HALT) |=> (mode_out == ($past(wake_in.nmi) ? DCP_NORMAL : DCP_HALT)))
    else $error("halt mode wake source wrong");

  lock_kept_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (pll_locked && s.mode != DCP_NORMAL && !ce_in) |=> pll_locked)
    else $error("lock lost while frozen in low-power mode");

  bypass_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && pll_bypass_in && bypass_tick) |=> (proc_clock_out != $past(proc_clock_out)))
    else $error("bypass clock did not follow reference");

  bypass_static_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && pll_bypass_in && !bypass_tick) |=> $stable(proc_clock_out))
    else $error("bypass clock moved with a still reference");

  mode_enter_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_NORMAL && mode_req_in.valid) |=> mode_out == $past(mode_req_in.mode))
    else $error("mode command not taken");

  freeze_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    !ce_in |=> ($stable(proc_clock_out) && $stable(mode_out)))
    else $error("state moved with enable low");

  // ****************************************
  // Checks: clock tree
  // ****************************************
  pll_runs_lp_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && !pll_bypass_in && pll_tick && s.mode != DCP_NORMAL)
      |=> (proc_clock_out != $past(proc_clock_out)))
    else $error("loop clock stopped in a low-power mode");

  pll_still_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && !pll_bypass_in && !pll_tick)
      |=> $stable(proc_clock_out))
    else $error("processor clock moved without a loop tick");

  bypass_no_lock_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && pll_bypass_in && !pll_locked && bypass_tick)
      |=> (proc_clock_out != $past(proc_clock_out)))
    else $error("bypass clock waited for lock");

  proc_move_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && proc_tick)
      |=> (proc_clock_out != $past(proc_clock_out)))
    else $error("clock pin missed a tick");

  proc_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && !proc_tick)
      |=> $stable(proc_clock_out))
    else $error("clock pin moved without a tick");

  core_on_rise_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_clk_en_out
      |-> $rose(proc_clock_out))
    else $error("core enable away from a clock rise");

  periph_on_rise_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    periph_clk_en_out
      |-> $rose(proc_clock_out))
    else $error("peripheral enable away from a clock rise");

  // ****************************************
  // Checks: mode machine
  // ****************************************
  core_normal_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    core_clk_en_out
      |-> ($past(mode_out) == DCP_NORMAL))
    else $error("core clocked outside normal mode");

  periph_awake_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    periph_clk_en_out
      |-> ($past(mode_out) == DCP_NORMAL || $past(mode_out) == DCP_IDLE))
    else $error("peripherals clocked in a deep mode");

  deep_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && (s.mode == DCP_SLEEP || s.mode == DCP_HALT))
      |=> (!core_clk_en_out && !periph_clk_en_out))
    else $error("deep mode left a clock running");

  sleep_wake_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_SLEEP && (wake_in.irq_ext || wake_in.nmi))
      |=> (mode_out == DCP_NORMAL && wake_out))
    else $error("sleep mode missed an external wake");

  sleep_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_SLEEP && !wake_in.irq_ext && !wake_in.nmi)
      |=> !wake_out)
    else $error("sleep mode woke on an internal source");

  halt_wake_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_HALT && wake_in.nmi)
      |=> wake_out)
    else $error("halt mode missed the NMI");

  halt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_HALT && !wake_in.nmi)
      |=> (mode_out == DCP_HALT && !wake_out))
    else $error("halt mode woke without the NMI");

  idle_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_IDLE && !any_wake)
      |=> (mode_out == DCP_IDLE && !wake_out))
    else $error("idle mode left without a wake");

  normal_no_wake_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode == DCP_NORMAL)
      |=> !wake_out)
    else $error("wake pulse while already in normal mode");

  lp_no_command_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (ce_in && s.mode != DCP_NORMAL && !any_wake)
      |=> $stable(mode_out))
    else $error("low-power mode changed without a wake");

  wake_to_normal_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    wake_out
      |-> (mode_out == DCP_NORMAL))
    else $error("wake pulse outside normal mode");

  wake_from_lp_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    wake_out
      |-> ($past(mode_out) != DCP_NORMAL))
    else $error("wake pulse without a low-power mode");

endmodule

// ---- dv/dcp_ref_osc.sv ----
module dcp_ref_osc (
  // Clock and control
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic [7:0] half_in,
  // Reference pin
  output logic            ref_clock_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Oscillator
  // ****************************************
  logic [7:0] cnt;

  initial begin
    ref_clock_out = 1'b0;
    cnt = 8'h00;
  end

  // Stopped oscillator holds its level, like a gated crystal output
  always @(posedge clk_in) begin
    if (!run_in) begin
      cnt <= #1 8'h00;
    end else if (cnt == half_in - 8'h01) begin
      cnt <= #1 8'h00;
      ref_clock_out <= #1 ~ref_clock_out;
    end else begin
      cnt <= #1 cnt + 8'h01;
    end
  end
endmodule

// ---- dv/test_dcp_clock_power.sv ----
module test_dcp_clock_power import dcp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals
  // ****************************************
  logic          clk_in;
  logic          resetn;
  logic          ce;
  logic          bypass;
  logic          run;
  logic [7:0]    half;
  logic          ref_clk;
  dcp_mode_req_t mode_req;
  dcp_wake_t     wake;
  logic          proc_clock_out;
  logic          core_en;
  logic          periph_en;
  dcp_mode_t     mode_out;
  logic          locked;
  logic          wake_out;
  int            err_count;
  int            check_count;
  int            cycles;

  dcp_ref_osc osc (.clk_in(clk_in), .run_in(run), .half_in(half), .ref_clock_out(ref_clk));

  dcp_clock_power dut (
    .clk_in           (clk_in),
    .resetn_in        (resetn),
    .ce_in            (ce),
    .ref_clock_in     (ref_clk),
    .pll_bypass_in    (bypass),
    .mode_req_in      (mode_req),
    .wake_in          (wake),
    .proc_clock_out   (proc_clock_out),
    .core_clk_en_out  (core_en),
    .periph_clk_en_out(periph_en),
    .mode_out         (mode_out),
    .pll_locked_out   (locked),
    .wake_out         (wake_out)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Settling lead-in so a window never starts mid-transition
  task automatic measure(input int n, output int tog, output int core, output int per);
    logic prev;
    tog = 0;
    core = 0;
    per = 0;
    repeat (10) @(posedge clk_in);
    #1;
    prev = proc_clock_out;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (proc_clock_out !== prev) tog++;
      if (core_en === 1'b1) core++;
      if (periph_en === 1'b1) per++;
      prev = proc_clock_out;
    end
  endtask

  task automatic request(input dcp_mode_t m);
    @(posedge clk_in);
    #1;
    mode_req.valid = 1'b1;
    mode_req.mode = m;
    @(posedge clk_in);
    #1;
    mode_req.valid = 1'b0;
  endtask

  task automatic pulse_wake(input dcp_wake_t w);
    @(posedge clk_in);
    #1;
    wake = w;
    @(posedge clk_in);
    #1;
    wake = '0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_bypass;
    int t, c, p;
    bypass = 1'b1;
    half = 8'h05;
    run = 1'b1;
    measure(100, t, c, p);
    check("bypass_toggles", t, 20);
    check("core_pulses", c, 10);
    check("periph_pulses", p, 10);
    run = 1'b0;
    measure(100, t, c, p);
    check("stopped_toggles", t, 0);
    run = 1'b1;
    measure(100, t, c, p);
    check("restart_toggles", t, 20);
  endtask

  task automatic test_modes;
    dcp_mode_t m;
    logic [2:0] okm;
    int t, c, p;
    ce = 1'b0;
    request(DCP_HALT);
    ce = 1'b1;
    check("gated_request", mode_out, DCP_NORMAL);
    pulse_wake(3'b111);
    check("normal_wake", wake_out, 1'b0);
    for (int k = 1; k < 4; k++) begin
      m = dcp_mode_t'(k);
      okm = (m == DCP_IDLE) ? 3'b111 : (m == DCP_SLEEP) ? 3'b011 : 3'b001;
      for (int s = 0; s < 3; s++) begin
        request(m);
        check("mode_entry", mode_out, m);
        measure(40, t, c, p);
        check("core_pulses", c, 0);
        check("periph_pulses", p, (m == DCP_IDLE) ? 4 : 0);
        request(DCP_NORMAL);
        check("lp_refused", mode_out, m);
        pulse_wake(dcp_wake_t'(3'b100 >> s));
        check("wake_pulse", wake_out, okm[2-s]);
        check("wake_mode", mode_out, okm[2-s] ? DCP_NORMAL : m);
        if (okm[2-s] !== 1'b1) begin
          pulse_wake(3'b001);
          check("nmi_wake", mode_out, DCP_NORMAL);
        end
      end
    end
  endtask

  task automatic test_pll;
    int t, c, p, n;
    run = 1'b0;
    @(posedge clk_in);
    #1;
    half = 8'h0a;
    bypass = 1'b0;
    run = 1'b1;
    n = 0;
    while (locked !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("pll_locked", locked, 1'b1);
    measure(80, t, c, p);
    check("pll_rate", (t >= 31 && t <= 33), 1'b1);
    request(DCP_SLEEP);
    // Freeze for exactly one reference period so no edge is mismeasured
    ce = 1'b0;
    repeat (20) @(posedge clk_in);
    #1;
    ce = 1'b1;
    check("frozen_mode", mode_out, DCP_SLEEP);
    repeat (200) @(posedge clk_in);
    #1;
    check("sleep_lock", locked, 1'b1);
    pulse_wake(3'b010);
    check("wake_lock", locked, 1'b1);
    measure(80, t, c, p);
    check("wake_rate", (t >= 31 && t <= 33), 1'b1);
  endtask

  task automatic test_reset_wake;
    for (int k = 1; k < 4; k++) begin
      request(dcp_mode_t'(k));
      check("reset_entry", mode_out, dcp_mode_t'(k));
      resetn = 1'b0;
      #1;
      check("reset_mode", mode_out, DCP_NORMAL);
      repeat (4) @(posedge clk_in);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      check("reset_wake", wake_out, 1'b0);
      request(DCP_IDLE);
      check("reset_ready", mode_out, DCP_IDLE);
      pulse_wake(3'b100);
      check("reset_idle_wake", mode_out, DCP_NORMAL);
    end
  endtask

  // ****************************************
  // Clock, timeout, main sequence
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 50000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    err_count = 0;
    check_count = 0;
    cycles = 0;
    resetn = 1'b0;
    ce = 1'b1;
    bypass = 1'b1;
    run = 1'b1;
    half = 8'h05;
    mode_req = '0;
    wake = '0;
    repeat (16) @(posedge clk_in);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    test_bypass();
    test_modes();
    test_pll();
    test_reset_wake();
    print_verdict();
  end
endmodule
